// [inc/dpmc_regs.vh]
// Register map, command codes and timing counts of the multiport DRAM host controller
`ifndef DPMC_REGS_VH
`define DPMC_REGS_VH
`define DPMC_A_CMD 8'h00
`define DPMC_A_ROW 8'h04
`define DPMC_A_COL 8'h08
`define DPMC_A_DATA 8'h0c
`define DPMC_A_MASK 8'h10
`define DPMC_A_CMASK 8'h14
`define DPMC_A_STAT 8'h18
`define DPMC_A_RDAT 8'h1c
`define DPMC_A_SER 8'h20
`define DPMC_A_PTR 8'h24
`define DPMC_OP_RWM 4'h0
`define DPMC_OP_FWM 4'h1
`define DPMC_OP_BWM 4'h2
`define DPMC_OP_BW 4'h3
`define DPMC_OP_LMR 4'h4
`define DPMC_OP_RMR 4'h5
`define DPMC_OP_RT 4'h6
`define DPMC_OP_MWT 4'h7
`define DPMC_OP_SRT 4'h8
`define DPMC_OP_MSWT 4'h9
`define DPMC_OP_RRR 4'ha
`define DPMC_CMD_BE_LSB 4
`define DPMC_ST_BUSY 0
`define DPMC_ST_SBUSY 1
`define DPMC_ST_DIRIN 2
`define DPMC_ST_CONV 3
`define DPMC_ST_SPLIT 4
`define DPMC_ST_PERS 5
`define DPMC_ST_ERR 6
`define DPMC_CLK_NS 8
`define DPMC_T_STEP_NS 20
`define DPMC_T_STEP_CYC ((`DPMC_T_STEP_NS + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS)
`define DPMC_T_PRE_NS 40
`define DPMC_T_PRE_CYC ((`DPMC_T_PRE_NS + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS)
`define DPMC_T_SCH_NS 32
`define DPMC_T_SCH_CYC ((`DPMC_T_SCH_NS + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS)
`define DPMC_SAM_HALF_LAST 8'hff
`endif

// [testbench/dpmc_ctrl_checker.sv]
// Pin protocol assertions for the multiport DRAM host controller
`timescale 1ns/1ps
module dpmc_ctrl_checker (
    // Clock, reset and strobes
    input logic mclk_i,
    input logic rstn_i,
    input logic row_strobe_n_o,
    input logic column_strobe_low_byte_n_o,
    input logic column_strobe_high_byte_n_o,
    input logic write_strobe_n_o,
    input logic transfer_output_enable_n_o,
    input logic special_function_select_o,
    input logic serial_shift_clock_o,
    // Address and enables
    input logic [8:0] addr_o,
    input logic [15:0] ram_data_lines_oe_o,
    input logic [15:0] serial_data_lines_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic [3:0] lv;
    // Column, write, transfer, select levels at row fall
    always @(posedge mclk_i or negedge rstn_i)
        if (!rstn_i)
            lv <= 4'h0;
        else if ($fell(row_strobe_n_o))
            lv <= {column_strobe_low_byte_n_o, write_strobe_n_o, transfer_output_enable_n_o,
                special_function_select_o};
    sequence xfer_s;
        $fell(row_strobe_n_o) && !transfer_output_enable_n_o;
    endsequence
    sequence col_s;
        $fell(column_strobe_low_byte_n_o) && !row_strobe_n_o;
    endsequence
    xfer_serial_still_a: assert property (xfer_s |-> ($stable(serial_shift_clock_o) &&
        serial_data_lines_oe_o == 16'h0)[*3]) else $error("serial port active in transfer");
    xfer_cas_high_a: assert property (xfer_s |-> column_strobe_low_byte_n_o && column_strobe_high_byte_n_o)
        else $error("column strobe low at transfer");
    xfer_trg_end_a: assert property (xfer_s |-> ##[1:30] $rose(transfer_output_enable_n_o)
        ##[0:10] $rose(row_strobe_n_o)) else $error("transfer not closed");
    block_setup_a: assert property (col_s ##0 (special_function_select_o && !lv[0]) |-> lv[3] && lv[1])
        else $error("block write setup levels");
    block_cols_a: assert property (col_s ##0 (special_function_select_o && !lv[0]) |-> addr_o[2:0] == 3'h0)
        else $error("block write low column bits");
    mask_load_a: assert property (($fell(write_strobe_n_o) || $fell(column_strobe_low_byte_n_o)) &&
        !write_strobe_n_o && !column_strobe_low_byte_n_o && !row_strobe_n_o && lv == 4'hf
        |-> ram_data_lines_oe_o == 16'hffff) else $error("mask data not driven");
    flash_no_col_a: assert property (col_s |-> lv != 4'hb) else $error("column strobe in flash write");
    refresh_levels_a: assert property ($fell(row_strobe_n_o) && !column_strobe_low_byte_n_o
        |-> write_strobe_n_o && !special_function_select_o) else $error("refresh levels");
endmodule // dpmc_ctrl_checker
bind dpmc_ctrl dpmc_ctrl_checker i_chk (.*);

// [testbench/dpmc_ctrl_tb_top.sv]
// Self-checking bench for the multiport DRAM host controller
`timescale 1ns/1ps
`include "dpmc_regs.vh"
module dpmc_ctrl_tb_top;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o;
    logic [31:0] v;
    logic row_strobe_n_o, column_strobe_low_byte_n_o, column_strobe_high_byte_n_o, write_strobe_n_o;
    logic transfer_output_enable_n_o, special_function_select_o, serial_shift_clock_o;
    logic [8:0] addr_o;
    logic [15:0] ram_data_lines_i, ram_data_lines_o, ram_data_lines_oe_o, dq_m;
    logic [15:0] serial_data_lines_i, serial_data_lines_o, serial_data_lines_oe_o, sdq_m;
    int n_errors = 0;
    int check_count = 0;
    always #4 mclk_i = ~mclk_i;
    assign ram_data_lines_i = (ram_data_lines_oe_o & ram_data_lines_o) | (~ram_data_lines_oe_o & dq_m);
    assign serial_data_lines_i = (serial_data_lines_oe_o & serial_data_lines_o) | (~serial_data_lines_oe_o & sdq_m);
    dpmc_ctrl i_dut (.*);
    dpmc_dram_model i_dram (.ras_n_i(row_strobe_n_o), .cas_n_i(column_strobe_low_byte_n_o),
        .we_n_i(write_strobe_n_o), .trg_n_i(transfer_output_enable_n_o), .dsf_i(special_function_select_o),
        .a_i(addr_o), .dq_i(ram_data_lines_i), .dq_o(dq_m), .sc_i(serial_shift_clock_o), .sdq_o(sdq_m));
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic idle();
        for (int i = 0; i < 500; i++)
        begin
            rd(`DPMC_A_STAT);
            if (v[1:0] === 2'b00)
                return;
        end
        n_errors++;
        $display("ERROR %0t: wait timed out", $time);
        tally_and_finish();
    endtask
    task automatic op(input logic [3:0] c, input logic [8:0] row, input logic [8:0] col);
        wr(`DPMC_A_ROW, {23'h0, row});
        wr(`DPMC_A_COL, {23'h0, col});
        wr(`DPMC_A_CMD, {28'h3, c});
        idle();
    endtask
    task automatic stat(input logic [31:0] m, input logic [31:0] exp);
        rd(`DPMC_A_STAT);
        chk(v & m, exp);
        wr(`DPMC_A_STAT, 32'h40);
    endtask
    task automatic t_reset();
        rd(`DPMC_A_MASK);
        chk(v, 32'hffff);
        rd(`DPMC_A_CMASK);
        chk(v, 32'hffff);
        rd(8'hfc);
        chk(v, 32'h0);
        op(4'h8, 9'h000, 9'h010);
        stat(32'h40, 32'h40);
    endtask
    task automatic t_mask();
        wr(`DPMC_A_DATA, 32'h5a3c);
        op(4'h4, 9'h011, 9'h000);
        chk({16'h0, i_dram.mask_reg}, 32'h5a3c);
        stat(32'h20, 32'h20);
        op(4'h5, 9'h011, 9'h000);
        rd(`DPMC_A_RDAT);
        chk(v, 32'h5a3c);
        op(4'ha, 9'h000, 9'h000);
        stat(32'h20, 32'h0);
    endtask
    task automatic t_read_xfer();
        op(4'h6, 9'h100, 9'h1fe);
        stat(32'h1c, 32'h08);
        for (int i = 0; i < 3; i++)
        begin
            wr(`DPMC_A_SER, 32'h0);
            idle();
            rd(`DPMC_A_SER);
            chk(v, 32'ha000 | ((32'h1fe + i) & 32'h1ff));
        end
        rd(`DPMC_A_PTR);
        chk(v, 32'h001);
        op(4'h8, 9'h100, 9'h0ff);
        stat(32'h40, 32'h40);
        op(4'h8, 9'h000, 9'h010);
        stat(32'h40, 32'h40);
        op(4'h8, 9'h100, 9'h010);
        stat(32'h5c, 32'h18);
    endtask
    task automatic t_write_xfer();
        op(4'h7, 9'h100, 9'h020);
        stat(32'h0c, 32'h0c);
        chk({16'h0, serial_data_lines_oe_o}, 32'hffff);
        wr(`DPMC_A_SER, 32'h1234);
        idle();
        chk({16'h0, serial_data_lines_o}, 32'h1234);
        rd(`DPMC_A_PTR);
        chk(v, 32'h021);
        op(4'h9, 9'h100, 9'h030);
        stat(32'h5c, 32'h1c);
        op(4'hb, 9'h100, 9'h030);
        stat(32'h40, 32'h40);
    endtask
    task automatic t_block();
        op(4'h3, 9'h012, 9'h12d);
        chk({23'h0, i_dram.col_reg}, 32'h128);
        op(4'h1, 9'h012, 9'h000);
        op(4'h0, 9'h012, 9'h005);
        op(4'h2, 9'h013, 9'h0f7);
        chk({23'h0, i_dram.col_reg}, 32'h0f0);
        stat(32'h40, 32'h0);
    endtask
    initial
    begin
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        t_reset();
        t_mask();
        t_read_xfer();
        t_write_xfer();
        t_block();
        tally_and_finish();
    end
endmodule // dpmc_ctrl_tb_top

// [testbench/dpmc_dram_model.sv]
// Behavioural multiport DRAM: mask register, cycle decode, serial buffer
`timescale 1ns/1ps
module dpmc_dram_model (
    // Strobes and address
    input wire ras_n_i,
    input wire cas_n_i,
    input wire we_n_i,
    input wire trg_n_i,
    input wire dsf_i,
    input wire [8:0] a_i,
    // Data lines and serial port
    input wire [15:0] dq_i,
    output wire [15:0] dq_o,
    input wire sc_i,
    output wire [15:0] sdq_o
);
    reg [3:0] lv_reg = 4'h0;
    reg [15:0] mask_reg = 16'hffff;
    reg [15:0] pat_reg = 16'h0f0f;
    reg [15:0] sq_reg = 16'h0000;
    reg [8:0] col_reg = 9'h000;
    reg [8:0] ptr_reg = 9'h000;
    reg out_reg = 1'b0;
    wire rd_mask = !ras_n_i && !cas_n_i && we_n_i && lv_reg == 4'hf;
    always @(negedge ras_n_i)
        lv_reg <= {cas_n_i, we_n_i, trg_n_i, dsf_i};
    // Later of the two falls takes the mask
    always @(negedge cas_n_i or negedge we_n_i)
        if (!ras_n_i && !cas_n_i && !we_n_i && lv_reg == 4'hf)
            mask_reg <= dq_i;
    always @(negedge cas_n_i)
        if (!ras_n_i)
        begin
            col_reg <= a_i;
            if (!lv_reg[1] && !lv_reg[0])
            begin
                ptr_reg <= a_i;
                out_reg <= lv_reg[2];
            end
        end
    // Released lines show a changing pattern
    always @(ras_n_i or cas_n_i)
        pat_reg = ~pat_reg;
    assign dq_o = rd_mask ? mask_reg : pat_reg;
    always @(posedge sc_i)
    begin
        sq_reg <= 16'ha000 | {7'h00, ptr_reg};
        ptr_reg <= ptr_reg + 9'h001;
    end
    assign sdq_o = out_reg ? sq_reg : ~sq_reg;
endmodule // dpmc_dram_model

// [verilog/dpmc_ctrl.v]
// Host controller driving a multiport DRAM: mask, flash, block write, transfers, serial port
//
// Function
// - Load mask captured at later strobe fall
// - Read mask keeps write strobe high
// - Block write: SPECIAL_FUNCTION_SELECT low, then high
// - Conventional transfer before split; direction kept
// - Transfer selected by levels at row fall
// - Read transfer pin levels
// - Masked write transfer pin levels
`timescale 1ns/1ps
`include "dpmc_regs.vh"
module dpmc_ctrl #(
    parameter STEP = `DPMC_T_STEP_CYC,
    parameter PRE = `DPMC_T_PRE_CYC,
    parameter SCH = `DPMC_T_SCH_CYC
) (
    // Clock and reset
    input wire mclk_i,
    input wire rstn_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // DRAM strobes and address
    output reg row_strobe_n_o,
    output reg column_strobe_low_byte_n_o,
    output reg column_strobe_high_byte_n_o,
    output reg write_strobe_n_o,
    output reg transfer_output_enable_n_o,
    output reg special_function_select_o,
    output reg [8:0] addr_o,
    // RAM data lines
    input wire [15:0] ram_data_lines_i,
    output reg [15:0] ram_data_lines_o,
    output reg [15:0] ram_data_lines_oe_o,
    // Serial port
    output wire serial_shift_clock_o,
    input wire [15:0] serial_data_lines_i,
    output wire [15:0] serial_data_lines_o,
    output wire [15:0] serial_data_lines_oe_o
);
    localparam S_IDLE = 3'd0;
    localparam S_SETUP = 3'd1;
    localparam S_RASL = 3'd2;
    localparam S_COLUMN_STROBE_LOW_BYTE = 3'd3;
    localparam S_WEL = 3'd4;
    localparam S_PRE = 3'd5;

    // Transfer kinds
    function is_xfer;
        input [3:0] op;
        begin
            is_xfer = (op == `DPMC_OP_RT) || (op == `DPMC_OP_MWT) || (op == `DPMC_OP_SRT) || (op == `DPMC_OP_MSWT);
        end
    endfunction

    function is_split;
        input [3:0] op;
        begin
            is_split = (op == `DPMC_OP_SRT) || (op == `DPMC_OP_MSWT);
        end
    endfunction

    // Ops whose mask is driven on data lines at row fall while pers_reg is clear
    function new_mask;
        input [3:0] op;
        begin
            new_mask = (op == `DPMC_OP_RWM) || (op == `DPMC_OP_FWM) || (op == `DPMC_OP_BWM) ||
                (op == `DPMC_OP_MWT) || (op == `DPMC_OP_MSWT);
        end
    endfunction

    reg rst_meta_reg;
    reg rst_sync_reg;
    reg [15:0] dq_meta_reg;
    reg [15:0] dq_sync_reg;
    reg [2:0] state_reg;
    reg [7:0] cnt_reg;
    reg [3:0] op_reg;
    reg [1:0] be_reg;
    reg [8:0] row_reg;
    reg [8:0] col_reg;
    reg [15:0] data_reg;
    reg [15:0] mask_reg;
    reg [15:0] cmask_reg;
    reg [15:0] rdat_reg;
    reg err_reg;
    reg dir_in_reg;
    reg conv_reg;
    reg pers_reg;
    reg half_reg;
    reg tap_load_reg;
    reg shift_reg;
    reg [15:0] shift_data_reg;
    wire ser_busy;
    wire ser_split;
    wire [15:0] ser_rdata;
    wire [8:0] ser_ptr;
    wire xfer_active;
    wire step_done;
    wire cmd_ok;
    wire ser_ok;
    wire [3:0] cmd_op;
    wire [6:0] status;

    assign xfer_active = (state_reg != S_IDLE) && is_xfer(op_reg);
    assign step_done = (cnt_reg == 8'h00);
    assign cmd_op = reg_wdata_i[3:0];
    // Refuse busy, split before conventional, cross-half split, split tap at half end
    assign cmd_ok = (state_reg == S_IDLE) && !ser_busy && cmd_op <= `DPMC_OP_RRR &&
        !(is_split(cmd_op) && (!conv_reg || row_reg[8] != half_reg ||
        col_reg[7:0] == `DPMC_SAM_HALF_LAST));
    assign ser_ok = !ser_busy && !xfer_active && conv_reg;
    assign status = {err_reg, pers_reg, ser_split, conv_reg, dir_in_reg, ser_busy, state_reg != S_IDLE};

    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Register port and command refusal
    always @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            reg_rdata_o <= 32'h00000000;
            row_reg <= 9'h000;
            col_reg <= 9'h000;
            data_reg <= 16'h0000;
            mask_reg <= 16'hffff;
            cmask_reg <= 16'hffff;
            err_reg <= 1'b0;
            shift_reg <= 1'b0;
            shift_data_reg <= 16'h0000;
        end
        else
        begin
            shift_reg <= 1'b0;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    `DPMC_A_ROW: reg_rdata_o <= {23'h000000, row_reg};
                    `DPMC_A_COL: reg_rdata_o <= {23'h000000, col_reg};
                    `DPMC_A_DATA: reg_rdata_o <= {16'h0000, data_reg};
                    `DPMC_A_MASK: reg_rdata_o <= {16'h0000, mask_reg};
                    `DPMC_A_CMASK: reg_rdata_o <= {16'h0000, cmask_reg};
                    `DPMC_A_STAT: reg_rdata_o <= {25'h0000000, status};
                    `DPMC_A_RDAT: reg_rdata_o <= {16'h0000, rdat_reg};
                    `DPMC_A_SER: reg_rdata_o <= {16'h0000, ser_rdata};
                    `DPMC_A_PTR: reg_rdata_o <= {23'h000000, ser_ptr};
                    default: reg_rdata_o <= 32'h00000000;
                endcase
            end
            else
                reg_rdata_o <= 32'h00000000;
            if (reg_wr_i)
            begin
                case (reg_addr_i)
                    `DPMC_A_ROW: row_reg <= reg_wdata_i[8:0];
                    `DPMC_A_COL: col_reg <= reg_wdata_i[8:0];
                    `DPMC_A_DATA: data_reg <= reg_wdata_i[15:0];
                    `DPMC_A_MASK: mask_reg <= reg_wdata_i[15:0];
                    `DPMC_A_CMASK: cmask_reg <= reg_wdata_i[15:0];
                    `DPMC_A_STAT:
                        if (reg_wdata_i[`DPMC_ST_ERR])
                            err_reg <= 1'b0;
                    `DPMC_A_CMD:
                        if (!cmd_ok)
                            err_reg <= 1'b1;
                    `DPMC_A_SER:
                        if (ser_ok)
                        begin
                            shift_reg <= 1'b1;
                            shift_data_reg <= reg_wdata_i[15:0];
                        end
                        else
                            err_reg <= 1'b1;
                    default: err_reg <= err_reg;
                endcase
            end
        end
    end

    // Pin sequencer
    always @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            dq_meta_reg <= 16'h0000;
            dq_sync_reg <= 16'h0000;
            state_reg <= S_IDLE;
            cnt_reg <= 8'h00;
            op_reg <= 4'h0;
            be_reg <= 2'b11;
            rdat_reg <= 16'h0000;
            dir_in_reg <= 1'b0;
            conv_reg <= 1'b0;
            pers_reg <= 1'b0;
            half_reg <= 1'b0;
            tap_load_reg <= 1'b0;
            row_strobe_n_o <= 1'b1;
            column_strobe_low_byte_n_o <= 1'b1;
            column_strobe_high_byte_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            transfer_output_enable_n_o <= 1'b1;
            special_function_select_o <= 1'b0;
            addr_o <= 9'h000;
            ram_data_lines_o <= 16'h0000;
            ram_data_lines_oe_o <= 16'h0000;
        end
        else
        begin
            dq_meta_reg <= ram_data_lines_i;
            dq_sync_reg <= dq_meta_reg;
            tap_load_reg <= 1'b0;
            if (!step_done)
                cnt_reg <= cnt_reg - 8'h01;
            case (state_reg)
                S_IDLE:
                    if (reg_wr_i && reg_addr_i == `DPMC_A_CMD && cmd_ok)
                    begin
                        op_reg <= cmd_op;
                        be_reg <= reg_wdata_i[`DPMC_CMD_BE_LSB + 1:`DPMC_CMD_BE_LSB];
                        state_reg <= S_SETUP;
                        cnt_reg <= STEP[7:0] - 8'h01;
                    end
                S_SETUP:
                begin
                    // Levels sampled by the device at the row strobe fall
                    addr_o <= row_reg;
                    column_strobe_low_byte_n_o <= (op_reg != `DPMC_OP_RRR);
                    column_strobe_high_byte_n_o <= (op_reg != `DPMC_OP_RRR);
                    transfer_output_enable_n_o <= !is_xfer(op_reg);
                    write_strobe_n_o <= !(new_mask(op_reg) && !(pers_reg && op_reg == `DPMC_OP_BW)) &&
                        op_reg != `DPMC_OP_BW ? 1'b1 : (op_reg == `DPMC_OP_BW);
                    special_function_select_o <= (op_reg == `DPMC_OP_FWM) || (op_reg == `DPMC_OP_LMR) ||
                        (op_reg == `DPMC_OP_RMR) || is_split(op_reg);
                    ram_data_lines_o <= mask_reg;
                    ram_data_lines_oe_o <= (new_mask(op_reg) && !pers_reg) ? 16'hffff : 16'h0000;
                    if (step_done)
                    begin
                        state_reg <= S_RASL;
                        cnt_reg <= STEP[7:0] - 8'h01;
                        row_strobe_n_o <= 1'b0;
                    end
                end
                S_RASL:
                begin
                    if (op_reg == `DPMC_OP_BW || op_reg == `DPMC_OP_BWM)
                    begin
                        addr_o <= {col_reg[8:3], 3'b000};
                        special_function_select_o <= 1'b1;
                        ram_data_lines_o <= cmask_reg;
                    end
                    else
                    begin
                        addr_o <= col_reg;
                        special_function_select_o <= 1'b0;
                        ram_data_lines_o <= data_reg;
                    end
                    ram_data_lines_oe_o <= (is_xfer(op_reg) || op_reg == `DPMC_OP_RMR ||
                        op_reg == `DPMC_OP_FWM || op_reg == `DPMC_OP_RRR) ? 16'h0000 : 16'hffff;
                    if (step_done)
                    begin
                        cnt_reg <= STEP[7:0] - 8'h01;
                        if (op_reg == `DPMC_OP_FWM || op_reg == `DPMC_OP_RRR)
                            state_reg <= S_PRE;
                        else
                        begin
                            state_reg <= S_COLUMN_STROBE_LOW_BYTE;
                            column_strobe_low_byte_n_o <= !be_reg[0];
                            column_strobe_high_byte_n_o <= !be_reg[1];
                        end
                    end
                end
                S_COLUMN_STROBE_LOW_BYTE:
                begin
                    // Read mask: write strobe held high, output enabled
                    if (op_reg == `DPMC_OP_RMR)
                    begin
                        write_strobe_n_o <= 1'b1;
                        transfer_output_enable_n_o <= 1'b0;
                    end
                    if (step_done)
                    begin
                        cnt_reg <= STEP[7:0] - 8'h01;
                        if (op_reg == `DPMC_OP_RMR)
                        begin
                            rdat_reg <= dq_sync_reg;
                            state_reg <= S_PRE;
                        end
                        else if (is_xfer(op_reg))
                        begin
                            // Transfer ends on the rising output enable
                            transfer_output_enable_n_o <= 1'b1;
                            state_reg <= S_PRE;
                        end
                        else
                        begin
                            write_strobe_n_o <= 1'b0;
                            state_reg <= S_WEL;
                        end
                    end
                end
                S_WEL:
                    if (step_done)
                    begin
                        cnt_reg <= PRE[7:0] - 8'h01;
                        state_reg <= S_PRE;
                        if (op_reg == `DPMC_OP_LMR)
                            pers_reg <= 1'b1;
                    end
                S_PRE:
                begin
                    row_strobe_n_o <= 1'b1;
                    column_strobe_low_byte_n_o <= 1'b1;
                    column_strobe_high_byte_n_o <= 1'b1;
                    write_strobe_n_o <= 1'b1;
                    transfer_output_enable_n_o <= 1'b1;
                    special_function_select_o <= 1'b0;
                    ram_data_lines_oe_o <= 16'h0000;
                    if (step_done)
                    begin
                        state_reg <= S_IDLE;
                        if (op_reg == `DPMC_OP_RRR)
                            pers_reg <= 1'b0;
                        if (is_xfer(op_reg))
                        begin
                            tap_load_reg <= 1'b1;
                            half_reg <= row_reg[8];
                            if (!is_split(op_reg))
                            begin
                                conv_reg <= 1'b1;
                                dir_in_reg <= (op_reg == `DPMC_OP_MWT);
                            end
                        end
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    dpmc_serial #(
        .SCH(SCH)
    ) u_serial (
        .mclk_i(mclk_i),
        .rst_n_i(rst_sync_reg),
        .hold_i(xfer_active),
        .dir_in_i(dir_in_reg),
        .tap_load_i(tap_load_reg),
        .tap_split_i(is_split(op_reg)),
        .tap_i(col_reg),
        .shift_i(shift_reg),
        .shift_data_i(shift_data_reg),
        .busy_o(ser_busy),
        .rdata_o(ser_rdata),
        .ptr_o(ser_ptr),
        .split_o(ser_split),
        .sc_o(serial_shift_clock_o),
        .sdq_o(serial_data_lines_o),
        .sdq_oe_o(serial_data_lines_oe_o),
        .sdq_i(serial_data_lines_i)
    );
endmodule // dpmc_ctrl

// [verilog/dpmc_serial.v]
// Serial port engine: shift clock divider, tap pointer and serial data lines
`timescale 1ns/1ps
`include "dpmc_regs.vh"
module dpmc_serial #(
    parameter SCH = `DPMC_T_SCH_CYC
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Control from the sequencer and status back to it
    input wire hold_i,
    input wire dir_in_i,
    input wire tap_load_i,
    input wire tap_split_i,
    input wire [8:0] tap_i,
    input wire shift_i,
    input wire [15:0] shift_data_i,
    output reg busy_o,
    output reg [15:0] rdata_o,
    output reg [8:0] ptr_o,
    output reg split_o,
    // Serial pins
    output reg sc_o,
    output reg [15:0] sdq_o,
    output reg [15:0] sdq_oe_o,
    input wire [15:0] sdq_i
);
    reg [15:0] sdq_meta_reg;
    reg [15:0] sdq_sync_reg;
    reg [7:0] other_tap_reg;
    reg [7:0] cnt_reg;
    reg phase_reg;

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sdq_meta_reg <= 16'h0000;
            sdq_sync_reg <= 16'h0000;
            other_tap_reg <= 8'h00;
            cnt_reg <= 8'h00;
            phase_reg <= 1'b0;
            busy_o <= 1'b0;
            rdata_o <= 16'h0000;
            ptr_o <= 9'h000;
            split_o <= 1'b0;
            sc_o <= 1'b0;
            sdq_o <= 16'h0000;
            sdq_oe_o <= 16'h0000;
        end
        else
        begin
            sdq_meta_reg <= sdq_i;
            sdq_sync_reg <= sdq_meta_reg;
            sdq_oe_o <= {16{dir_in_i & ~hold_i}};
            if (tap_load_i)
            begin
                if (tap_split_i)
                begin
                    other_tap_reg <= tap_i[7:0];
                    split_o <= 1'b1;
                end
                else
                begin
                    ptr_o <= tap_i;
                    split_o <= 1'b0;
                end
            end
            else if (busy_o)
            begin
                if (cnt_reg != 8'h00)
                    cnt_reg <= cnt_reg - 8'h01;
                else if (!phase_reg)
                begin
                    sc_o <= 1'b0;
                    phase_reg <= 1'b1;
                    cnt_reg <= SCH[7:0] - 8'h01;
                    if (!dir_in_i)
                        rdata_o <= sdq_sync_reg;
                end
                else
                begin
                    busy_o <= 1'b0;
                    phase_reg <= 1'b0;
                    if (split_o && ptr_o[7:0] == `DPMC_SAM_HALF_LAST)
                        ptr_o <= {~ptr_o[8], other_tap_reg};
                    else if (split_o)
                        ptr_o <= {ptr_o[8], ptr_o[7:0] + 8'h01};
                    else
                        ptr_o <= ptr_o + 9'h001;
                end
            end
            else if (shift_i && !hold_i)
            begin
                busy_o <= 1'b1;
                sc_o <= 1'b1;
                cnt_reg <= SCH[7:0] - 8'h01;
                if (dir_in_i)
                    sdq_o <= shift_data_i;
            end
        end
    end
endmodule // dpmc_serial
